// ==== verilog/dac_channel_config_regs.sv ====
/*
 * Channel configuration register bank of a dual converter: routing,
 * bit reversal, sync source choice, staged offset correction with
 * autosync, serial port mode and sleep and reference controls.
 * Assumes the serial control port front end delivers register reads
 * and writes as single-cycle strobes on core_clk; sample data and the
 * frame marker come from logic on core_clk; the sync strobe is a pin.
 */
`timescale 1ns/100ps

// How it works
// [R1] Copy bit sends channel A to converter B.
// [R2] Copy bit sends channel B to converter A.
// [R3] Sync source: strobe pin or frame marker.
// [R4] Reverse bit flips input sample bit order.
// [R5] Offset A: 13 bits, low byte plus high five.
// [R6] Offset B: 13 bits, low byte plus high five.
// [R7] Writing offset A low loads all offsets.
// [R8] Other offset writes only stage new values.
// [R9] Host writes offset A low byte last.
// [R10] Four-pin bit turns fault pin into read data.
// [R11] Clock path sleep bits per converter.
// [R12] Host keeps clock path awake unless chip down.
// [R13] Temperature sensor enable, resets to one.
// [R14] Receiver sleep also silences sync strobe receiver.
// [R15] Sleep bits power down converter B and A.
// [R16] Reference select: internal or external.
// [R17] Host syncs clock divider only at initialisation.
// [R18] Reserved bits keep defaults, ignore writes.
module dac_channel_config_regs
    import dac_cfg_pkg::*;
#(
    parameter int SAMPLE_WIDTH = SAMPLE_W
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    output logic [DATA_W-1:0] regRdData,
    output logic regRdValid,
    input wire logic [SAMPLE_WIDTH-1:0] sampleAIn,
    input wire logic [SAMPLE_WIDTH-1:0] sampleBIn,
    output logic [SAMPLE_WIDTH-1:0] sampleAOut,
    output logic [SAMPLE_WIDTH-1:0] sampleBOut,
    input wire logic externalSyncStrobe,
    input wire logic frameMarker,
    output logic syncSource,
    input wire logic alarmLevel,
    input wire logic serialReadData,
    output logic fourPinPortSelect,
    output logic faultPinOut,
    output logic clkPathSleepA,
    output logic clkPathSleepB,
    output logic dacSleepA,
    output logic dacSleepB,
    output logic clkRecvSleep,
    output logic tempSensorEnable,
    output logic externalRefSelect,
    output logic [OFFSET_W-1:0] activeOffsetA,
    output logic [OFFSET_W-1:0] activeOffsetB
);

    // Only the writable bits change; the rest keep their reset value.
    function automatic logic [DATA_W-1:0] writeMasked(
        input logic [DATA_W-1:0] oldValue,
        input logic [DATA_W-1:0] newValue,
        input logic [DATA_W-1:0] mask
    );
        writeMasked = (oldValue & ~mask) | (newValue & mask);
    endfunction

    function automatic logic isWrite(
        input logic wrEn,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        isWrite = wrEn && (addr == target);
    endfunction

    logic [DATA_W-1:0] route_q;
    logic [DATA_W-1:0] offALow_q;
    logic [DATA_W-1:0] offBLow_q;
    logic [DATA_W-1:0] offAHigh_q;
    logic [DATA_W-1:0] offBHigh_q;
    logic [DATA_W-1:0] power_q;
    logic [DATA_W-1:0] ref_q;

    logic wrRoute;
    logic wrOffALow;
    logic wrOffBLow;
    logic wrOffAHigh;
    logic wrOffBHigh;
    logic wrPower;
    logic wrRef;

    assign wrRoute = isWrite(regWrEn, regAddr, ADDR_ROUTE);
    assign wrOffALow = isWrite(regWrEn, regAddr, ADDR_OFFA_LO);
    assign wrOffBLow = isWrite(regWrEn, regAddr, ADDR_OFFB_LO);
    assign wrOffAHigh = isWrite(regWrEn, regAddr, ADDR_OFFA_HI);
    assign wrOffBHigh = isWrite(regWrEn, regAddr, ADDR_OFFB_HI);
    assign wrPower = isWrite(regWrEn, regAddr, ADDR_POWER);
    assign wrRef = isWrite(regWrEn, regAddr, ADDR_REF);

    // Control registers.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            route_q <= RST_ROUTE;
            power_q <= RST_POWER; // [R13]
            ref_q <= RST_REF;
        end else begin
            if (wrRoute) begin
                route_q <= writeMasked(route_q, regWrData, MASK_ROUTE); // [R18]
            end
            if (wrPower) begin
                power_q <= writeMasked(power_q, regWrData, MASK_POWER); // [R18]
            end
            if (wrRef) begin
                ref_q <= writeMasked(ref_q, regWrData, MASK_REF); // [R18]
            end
        end
    end

    // Staged offset registers.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            offALow_q <= RST_OFFA_LO;
            offBLow_q <= RST_OFFB_LO;
            offAHigh_q <= RST_OFFA_HI;
            offBHigh_q <= RST_OFFB_HI;
        end else begin
            if (wrOffALow) begin
                offALow_q <= regWrData;
            end
            if (wrOffBLow) begin
                offBLow_q <= writeMasked(offBLow_q, regWrData, MASK_OFF_LO); // [R8]
            end
            if (wrOffAHigh) begin
                offAHigh_q <= writeMasked(offAHigh_q, regWrData, MASK_OFFA_HI); // [R8]
            end
            if (wrOffBHigh) begin
                offBHigh_q <= writeMasked(offBHigh_q, regWrData, MASK_OFFB_HI); // [R8]
            end
        end
    end

    // A write to the offset A low byte loads the three other staged bytes at
    // once, using the byte being written for the low eight bits of offset A.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            activeOffsetA <= '0;
            activeOffsetB <= '0;
        end else if (wrOffALow) begin
            activeOffsetA <= {offAHigh_q[OFF_HI_MSB:OFF_HI_LSB], regWrData}; // [R7] [R5]
            activeOffsetB <= {offBHigh_q[OFF_HI_MSB:OFF_HI_LSB], offBLow_q}; // [R7] [R6]
        end
    end

    // Register reads answer one cycle later; unmapped addresses read zero.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= '0;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                unique case (regAddr)
                    ADDR_ROUTE: regRdData <= route_q;
                    ADDR_OFFA_LO: regRdData <= offALow_q;
                    ADDR_OFFB_LO: regRdData <= offBLow_q;
                    ADDR_OFFA_HI: regRdData <= offAHigh_q;
                    ADDR_OFFB_HI: regRdData <= offBHigh_q;
                    ADDR_POWER: regRdData <= power_q;
                    ADDR_REF: regRdData <= ref_q;
                    default: regRdData <= '0;
                endcase
            end
        end
    end

    // Static controls leave the bank straight from their flip-flops.
    assign fourPinPortSelect = offBHigh_q[BIT_FOUR_PIN]; // [R10]
    assign clkPathSleepA = offBHigh_q[BIT_CLKPATH_A]; // [R11]
    assign clkPathSleepB = offBHigh_q[BIT_CLKPATH_B]; // [R11]
    assign tempSensorEnable = power_q[BIT_TSENSE]; // [R13]
    assign clkRecvSleep = power_q[BIT_CLKRX_SLEEP]; // [R14]
    assign dacSleepB = power_q[BIT_SLEEP_B]; // [R15]
    assign dacSleepA = power_q[BIT_SLEEP_A]; // [R15]
    assign externalRefSelect = ref_q[BIT_EXT_REF]; // [R16]

    // The fault pin carries serial read data in four-pin mode.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            faultPinOut <= 1'b0;
        end else begin
            faultPinOut <= fourPinPortSelect ? serialReadData : alarmLevel; // [R10]
        end
    end

    // The strobe pin is asynchronous and is synchronised before use.
    logic strobeMeta_q;
    logic strobeSync_q;
    logic strobeAwake;
    logic syncSource_d;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobeMeta_q <= 1'b0;
            strobeSync_q <= 1'b0;
        end else begin
            strobeMeta_q <= externalSyncStrobe;
            strobeSync_q <= strobeMeta_q;
        end
    end

    // A sleeping clock receiver also mutes the strobe receiver.
    assign strobeAwake = strobeSync_q && !clkRecvSleep; // [R14]
    assign syncSource_d = (route_q[BIT_SYNC_SEL] == SYNC_SEL_FRAME) ?
        frameMarker : strobeAwake; // [R3]

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncSource <= 1'b0;
        end else begin
            syncSource <= syncSource_d; // [R3]
        end
    end

    // Channel routing; with both copy bits set the channels swap.
    logic [SAMPLE_WIDTH-1:0] pathAIn;
    logic [SAMPLE_WIDTH-1:0] pathBIn;

    assign pathBIn = route_q[BIT_A_TO_B] ? sampleAIn : sampleBIn; // [R1]
    assign pathAIn = route_q[BIT_B_TO_A] ? sampleBIn : sampleAIn; // [R2]

    dac_sample_path #(
        .SAMPLE_W(SAMPLE_WIDTH),
        .OFFSET_W(OFFSET_W)
    ) pathA (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sampleIn(pathAIn),
        .reverseBits(route_q[BIT_REVERSE]), // [R4]
        .offset(activeOffsetA),
        .sleep(dacSleepA),
        .sampleOut(sampleAOut)
    );

    dac_sample_path #(
        .SAMPLE_W(SAMPLE_WIDTH),
        .OFFSET_W(OFFSET_W)
    ) pathB (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sampleIn(pathBIn),
        .reverseBits(route_q[BIT_REVERSE]), // [R4]
        .offset(activeOffsetB),
        .sleep(dacSleepB),
        .sampleOut(sampleBOut)
    );

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (!rst_b);

    sequence commitWrite;
        regWrEn && (regAddr == ADDR_OFFA_LO);
    endsequence

    sequence stageWrite;
        regWrEn && (regAddr == ADDR_OFFB_LO || regAddr == ADDR_OFFA_HI
            || regAddr == ADDR_OFFB_HI);
    endsequence

    sequence plainCopy(logic copyBit, logic otherBit);
        copyBit && !otherBit && activeOffsetA == activeOffsetB
            && !dacSleepA && !dacSleepB;
    endsequence

    sequence strobeMuted;
        clkRecvSleep && route_q[BIT_SYNC_SEL] == SYNC_SEL_STROBE;
    endsequence

    copy_a_to_b_a: assert property ( // [R1]
        plainCopy(route_q[BIT_A_TO_B], route_q[BIT_B_TO_A])
            |=> sampleBOut == sampleAOut)
        else $error("Converter B does not follow channel A.");

    copy_b_to_a_a: assert property ( // [R2]
        plainCopy(route_q[BIT_B_TO_A], route_q[BIT_A_TO_B])
            |=> sampleAOut == sampleBOut)
        else $error("Converter A does not follow channel B.");

    frame_sync_source_a: assert property ( // [R3]
        (route_q[BIT_SYNC_SEL] == SYNC_SEL_FRAME) ##0 $changed(frameMarker)
            |=> syncSource == $past(frameMarker))
        else $error("Sync source does not follow frame marker.");

    bit_reverse_a: assert property ( // [R4]
        (route_q[BIT_REVERSE] && !route_q[BIT_B_TO_A] && activeOffsetA == '0
            && !dacSleepA)
            |=> sampleAOut[0] == $past(sampleAIn[SAMPLE_WIDTH-1]))
        else $error("Sample bit order not reversed.");

    offset_commit_a: assert property ( // [R7]
        commitWrite |=> activeOffsetA == {$past(offAHigh_q[OFF_HI_MSB:OFF_HI_LSB]),
            $past(regWrData)} && activeOffsetB == {$past(offBHigh_q[7:3]),
            $past(offBLow_q)})
        else $error("Autosync did not load all offsets.");

    offset_staged_a: assert property ( // [R8]
        stageWrite ##0 !wrOffALow |=> $stable(activeOffsetA) && $stable(activeOffsetB))
        else $error("Staging write changed the active offset.");

    fault_pin_mode_a: assert property ( // [R10]
        fourPinPortSelect |=> faultPinOut == $past(serialReadData))
        else $error("Fault pin does not carry read data.");

    tsense_write_a: assert property ( // [R13]
        wrPower |=> tempSensorEnable == $past(regWrData[BIT_TSENSE]))
        else $error("Temperature sensor enable not written.");

    strobe_sleep_a: assert property ( // [R14]
        strobeMuted ##1 strobeMuted |-> !syncSource)
        else $error("Strobe passed while receiver asleep.");

    reserved_bits_a: assert property ( // [R18]
        route_q[5:2] == 4'h0 && power_q[1:0] == 2'h3 && ref_q[7:3] == 5'h00
            && offAHigh_q[2:0] == 3'h0 && power_q[5:4] == 2'h0 && ref_q[1:0] == 2'h0)
        else $error("Reserved bits left their defaults.");

    sleep_forces_zero_a: assert property ( // [R15]
        (dacSleepA |=> sampleAOut == '0) and (dacSleepB |=> sampleBOut == '0))
        else $error("Sleeping converter output not zero.");

    clkpath_write_a: assert property ( // [R11]
        wrOffBHigh |=> clkPathSleepA == $past(regWrData[BIT_CLKPATH_A])
            && clkPathSleepB == $past(regWrData[BIT_CLKPATH_B]))
        else $error("Clock path sleep bits not written.");

    ref_select_write_a: assert property ( // [R16]
        wrRef |=> externalRefSelect == $past(regWrData[BIT_EXT_REF]))
        else $error("Reference select not written.");

endmodule

// ==== verilog/dac_cfg_pkg.sv ====
/*
 * Constants for the channel configuration register bank: register
 * addresses, reset values, writable-bit masks and field positions.
 * Assumes an 8-bit register file with a 5-bit register address.
 */
package dac_cfg_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int OFFSET_W = 13;

    localparam logic [ADDR_W-1:0] ADDR_ROUTE = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_OFFA_LO = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_OFFB_LO = 5'h15;
    localparam logic [ADDR_W-1:0] ADDR_OFFA_HI = 5'h16;
    localparam logic [ADDR_W-1:0] ADDR_OFFB_HI = 5'h17;
    localparam logic [ADDR_W-1:0] ADDR_POWER = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_REF = 5'h19;

    localparam logic [DATA_W-1:0] RST_ROUTE = 8'h00;
    localparam logic [DATA_W-1:0] RST_OFFA_LO = 8'h00;
    localparam logic [DATA_W-1:0] RST_OFFB_LO = 8'h00;
    localparam logic [DATA_W-1:0] RST_OFFA_HI = 8'h00;
    localparam logic [DATA_W-1:0] RST_OFFB_HI = 8'h00;
    localparam logic [DATA_W-1:0] RST_POWER = 8'h83;
    localparam logic [DATA_W-1:0] RST_REF = 8'h00;

    // Bits that software may change; all others keep their reset value.
    localparam logic [DATA_W-1:0] MASK_ROUTE = 8'hC3;
    localparam logic [DATA_W-1:0] MASK_OFF_LO = 8'hFF;
    localparam logic [DATA_W-1:0] MASK_OFFA_HI = 8'hF8;
    localparam logic [DATA_W-1:0] MASK_OFFB_HI = 8'hFF;
    localparam logic [DATA_W-1:0] MASK_POWER = 8'hCC;
    localparam logic [DATA_W-1:0] MASK_REF = 8'h04;

    localparam int BIT_A_TO_B = 7;
    localparam int BIT_B_TO_A = 6;
    localparam int BIT_SYNC_SEL = 1;
    localparam int BIT_REVERSE = 0;
    localparam int OFF_HI_MSB = 7;
    localparam int OFF_HI_LSB = 3;
    localparam int BIT_FOUR_PIN = 2;
    localparam int BIT_CLKPATH_A = 1;
    localparam int BIT_CLKPATH_B = 0;
    localparam int BIT_TSENSE = 7;
    localparam int BIT_CLKRX_SLEEP = 6;
    localparam int BIT_SLEEP_B = 3;
    localparam int BIT_SLEEP_A = 2;
    localparam int BIT_EXT_REF = 2;

    localparam logic SYNC_SEL_STROBE = 1'b0;
    localparam logic SYNC_SEL_FRAME = 1'b1;

endpackage

// ==== verilog/dac_sample_path.sv ====
/*
 * One converter sample path: optional bit-order reversal, offset
 * correction with saturation and midscale forcing while asleep.
 * Assumes two's complement samples and a signed offset on core_clk.
 */
`timescale 1ns/100ps
module dac_sample_path #(
    parameter int SAMPLE_W = 16,
    parameter int OFFSET_W = 13
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [SAMPLE_W-1:0] sampleIn,
    input wire logic reverseBits,
    input wire logic [OFFSET_W-1:0] offset,
    input wire logic sleep,
    output logic [SAMPLE_W-1:0] sampleOut
);

    logic [SAMPLE_W-1:0] reversed;
    logic [SAMPLE_W-1:0] ordered;
    logic [SAMPLE_W:0] sum;
    logic [SAMPLE_W-1:0] sampleOut_d;

    for (genvar i = 0; i < SAMPLE_W; i++) begin : g_rev
        assign reversed[i] = sampleIn[SAMPLE_W-1-i];
    end

    assign ordered = reverseBits ? reversed : sampleIn;
    assign sum = {ordered[SAMPLE_W-1], ordered}
        + {{(SAMPLE_W+1-OFFSET_W){offset[OFFSET_W-1]}}, offset};

    // Overflow clips to the nearest full-scale code instead of wrapping.
    always_comb begin
        if (sleep) begin
            sampleOut_d = '0;
        end else if (sum[SAMPLE_W] != sum[SAMPLE_W-1]) begin
            sampleOut_d = {sum[SAMPLE_W], {(SAMPLE_W-1){~sum[SAMPLE_W]}}};
        end else begin
            sampleOut_d = sum[SAMPLE_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sampleOut <= '0;
        end else begin
            sampleOut <= sampleOut_d;
        end
    end

endmodule

// ==== verif/host_model.sv ====
/*
 * Host processor model that reaches the configuration registers over
 * the parallel strobe port that stands for the serial control port.
 * Assumes the device takes requests on rising core_clk and answers a
 * read exactly one cycle later.
 */
`timescale 1ns/100ps
module host_model
    import dac_cfg_pkg::*;
(
    input wire logic core_clk,
    output logic regWrEn,
    output logic regRdEn,
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWrData,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 5'h00;
        regWrData = 8'h00;
    end

    // Idle address and data carry the inverse of the last value so that
    // nothing in the device can lean on a stale bus.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        #1;
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge core_clk);
        #1;
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
        output logic v);
        @(posedge core_clk);
        #1;
        regRdEn = 1'b1;
        regAddr = a;
        @(posedge core_clk);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
        v = regRdValid;
    endtask

    // The low byte of offset A goes last, since it loads all four.
    task automatic setOffsets(input logic [12:0] a, input logic [12:0] b,
        input logic [2:0] ctl);
        wr(ADDR_OFFB_LO, b[7:0]);
        wr(ADDR_OFFA_HI, {a[12:8], 3'h0});
        wr(ADDR_OFFB_HI, {b[12:8], ctl});
        wr(ADDR_OFFA_LO, a[7:0]);
    endtask
endmodule

// ==== verif/testbench.sv ====
/*
 * Self-checking bench for the channel configuration register bank.
 * Assumes the host model drives the register port; the bench drives
 * samples, sync sources and fault pin sources one step after core_clk.
 */
`timescale 1ns/100ps
module testbench;
    import dac_cfg_pkg::*;
    logic core_clk, rst_b, regWrEn, regRdEn, regRdValid;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, r, flags;
    logic [SAMPLE_W-1:0] sampleAIn, sampleBIn, sampleAOut, sampleBOut, aS, bS;
    logic externalSyncStrobe, frameMarker, syncSource, alarmLevel, serialReadData;
    logic fourPinPortSelect, faultPinOut, clkPathSleepA, clkPathSleepB;
    logic dacSleepA, dacSleepB, clkRecvSleep, tempSensorEnable, externalRefSelect;
    logic [OFFSET_W-1:0] activeOffsetA, activeOffsetB;
    int error_cnt = 0;
    int num_checks = 0;
    typedef struct {logic [4:0] a; logic [7:0] w; logic [7:0] e;} row_t;
    row_t rows[16] = '{'{5'h13, 8'hFF, 8'hC3}, '{5'h15, 8'hFF, 8'hFF}, '{5'h16, 8'hFF, 8'hF8},
        '{5'h18, 8'hFF, 8'hCF}, '{5'h17, 8'hFF, 8'hFF}, '{5'h14, 8'hFF, 8'hFF},
        '{5'h19, 8'hFF, 8'h04}, '{5'h1A, 8'hFF, 8'h00}, '{5'h12, 8'hFF, 8'h00},
        '{5'h13, 8'h00, 8'h00}, '{5'h15, 8'h00, 8'h00}, '{5'h16, 8'h00, 8'h00},
        '{5'h17, 8'h00, 8'h00}, '{5'h14, 8'h00, 8'h00}, '{5'h18, 8'h00, 8'h03},
        '{5'h19, 8'h00, 8'h00}};
    logic [7:0] rstVals[7] = '{RST_ROUTE, RST_OFFA_LO, RST_OFFB_LO, RST_OFFA_HI,
        RST_OFFB_HI, RST_POWER, RST_REF};
    logic [7:0] routes[5] = '{8'h00, 8'h80, 8'h40, 8'hC0, 8'h01};

    assign flags = {fourPinPortSelect, clkPathSleepA, clkPathSleepB, clkRecvSleep,
        dacSleepA, dacSleepB, tempSensorEnable, externalRefSelect};

    dac_channel_config_regs i_dut (.core_clk, .rst_b, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regRdValid, .sampleAIn, .sampleBIn, .sampleAOut,
        .sampleBOut, .externalSyncStrobe, .frameMarker, .syncSource, .alarmLevel,
        .serialReadData, .fourPinPortSelect, .faultPinOut, .clkPathSleepA,
        .clkPathSleepB, .dacSleepA, .dacSleepB, .clkRecvSleep, .tempSensorEnable,
        .externalRefSelect, .activeOffsetA, .activeOffsetB);

    host_model i_host (.core_clk, .regWrEn, .regRdEn, .regAddr, .regWrData,
        .regRdData, .regRdValid);

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic wrap_up;
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bad(input string m);
        error_cnt++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic chkRd(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_host.rd(a, d, v);
        num_checks++;
        if (d !== e || v !== 1'b1) bad($sformatf("read %h got %h exp %h", a, d, e));
    endtask

    task automatic chkVal(input logic [15:0] g, input logic [15:0] e, input string m);
        num_checks++;
        if (g !== e) bad($sformatf("%s got %h exp %h", m, g, e));
    endtask

    task automatic chkFlg(input logic [7:0] e);
        num_checks++;
        if (flags !== e) bad($sformatf("control levels got %h exp %h", flags, e));
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Offset is a signed 13-bit value added with saturation.
    function automatic logic [15:0] corr(input logic [15:0] s, input logic [12:0] o);
        int v;
        v = $signed(s) + $signed(o);
        if (v > 32767) return 16'h7FFF;
        if (v < -32768) return 16'h8000;
        return v[15:0];
    endfunction

    initial begin
        #200000;
        bad("run timed out");
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        sampleAIn = 16'h1234;
        sampleBIn = 16'h7FF0;
        externalSyncStrobe = 1'b0;
        frameMarker = 1'b0;
        alarmLevel = 1'b0;
        serialReadData = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        chkFlg(8'h02);
        for (int i = 0; i < 7; i++) begin
            chkRd(5'h13 + 5'(i), rstVals[i]);
        end
        foreach (rows[i]) begin
            i_host.wr(rows[i].a, rows[i].w);
            chkRd(rows[i].a, rows[i].e);
        end
        i_host.wr(ADDR_OFFB_LO, 8'h34);
        i_host.wr(ADDR_OFFA_HI, 8'hA8);
        i_host.wr(ADDR_OFFB_HI, 8'h50);
        chkVal({3'h0, activeOffsetA}, 16'h0000, "staged offset A");
        chkVal({3'h0, activeOffsetB}, 16'h0000, "staged offset B");
        i_host.wr(ADDR_OFFA_LO, 8'h05);
        chkVal({3'h0, activeOffsetA}, 16'h1505, "offset A");
        chkVal({3'h0, activeOffsetB}, 16'h0A34, "offset B");
        foreach (routes[i]) begin
            i_host.wr(ADDR_ROUTE, routes[i]);
            step(1);
            aS = routes[i][6] ? sampleBIn : sampleAIn;
            bS = routes[i][7] ? sampleAIn : sampleBIn;
            if (routes[i][0]) begin
                aS = {<<{aS}};
                bS = {<<{bS}};
            end
            chkVal(sampleAOut, corr(aS, 13'h1505), "converter A");
            chkVal(sampleBOut, corr(bS, 13'h0A34), "converter B");
        end
        i_host.wr(ADDR_POWER, 8'h0C);
        step(1);
        chkVal(sampleAOut | sampleBOut, 16'h0000, "sleeping outputs");
        chkFlg(8'h0C);
        i_host.wr(ADDR_POWER, 8'h08);
        chkFlg(8'h04);
        i_host.wr(ADDR_POWER, 8'h4C);
        i_host.wr(ADDR_OFFB_HI, 8'h57);
        chkFlg(8'hFC);
        alarmLevel = 1'b1;
        step(1);
        chkVal({15'h0, faultPinOut}, 16'h0000, "fault pin");
        serialReadData = 1'b1;
        alarmLevel = 1'b0;
        step(1);
        chkVal({15'h0, faultPinOut}, 16'h0001, "fault pin");
        serialReadData = 1'b0;
        alarmLevel = 1'b1;
        i_host.wr(ADDR_OFFB_HI, 8'h50);
        step(1);
        chkVal({15'h0, faultPinOut}, 16'h0001, "fault pin");
        i_host.wr(ADDR_POWER, 8'h00);
        i_host.wr(ADDR_REF, 8'h04);
        chkFlg(8'h01);
        i_host.wr(ADDR_ROUTE, 8'h02);
        frameMarker = 1'b1;
        step(1);
        chkVal({15'h0, syncSource}, 16'h0001, "frame sync");
        frameMarker = 1'b0;
        step(1);
        chkVal({15'h0, syncSource}, 16'h0000, "frame sync");
        i_host.wr(ADDR_ROUTE, 8'h00);
        externalSyncStrobe = 1'b1;
        step(2);
        chkVal({15'h0, syncSource}, 16'h0000, "strobe sync");
        step(1);
        chkVal({15'h0, syncSource}, 16'h0001, "strobe sync");
        i_host.wr(ADDR_POWER, 8'h40);
        step(3);
        chkVal({15'h0, syncSource}, 16'h0000, "gated strobe");
        chkFlg(8'h11);
        i_host.setOffsets(13'h0000, 13'h0000, 3'h0);
        chkVal({3'h0, activeOffsetA}, 16'h0000, "cleared offset A");
        chkVal({3'h0, activeOffsetB}, 16'h0000, "cleared offset B");
        i_host.wr(ADDR_ROUTE, 8'h80);
        step(1);
        chkVal(sampleBOut, 16'h1234, "copy A to B");
        chkVal(sampleAOut, 16'h1234, "channel A kept");
        i_host.wr(ADDR_ROUTE, 8'h40);
        step(1);
        chkVal(sampleAOut, 16'h7FF0, "copy B to A");
        chkVal(sampleBOut, 16'h7FF0, "channel B kept");
        i_host.wr(ADDR_ROUTE, 8'h01);
        step(1);
        chkVal(sampleAOut, 16'h2C48, "reversed A");
        wrap_up();
    end
endmodule
